// [verilog/tsw_switch.sv]
// Processor control and serial switching core of the eight-stream time-slot interchange.
//
// Behaviour
// RULE1 - Page line low selects the control register; channel lines are ignored.
// RULE2 - Page line high: channel lines pick channel 0-31 in selected memory and stream.
// RULE3 - Control bits 4:3 pick memory: 01 data, 10 low, 11 high connection.
// RULE4 - Control bits 2:0 give the stream number 0 to 7 in binary.
// RULE5 - Software writes only the listed control values; others are test-reserved.
// RULE6 - Control bit 7 set: reads come from data memory, writes go to low connection.
// RULE7 - Control bit 6 set: every output channel sends its low connection byte.
// RULE8 - Global message bit forces high connection bits 2 and 0 to one.
// RULE9 - High connection bit 2 set: send the low connection byte itself.
// RULE10 - Otherwise send the data memory byte addressed by the low connection entry.
// RULE11 - Low connection bits 7:5 are source stream, bits 4:0 source channel.
// RULE12 - Drive enable pin low floats every serial output; the code floats the stream outputs, not the control-bit output.
// RULE13 - Drive enable high and control bit 6 set drives every output channel.
// RULE14 - Otherwise high connection bit 0 enables that stream-channel driver.
// RULE15 - High connection bit 1 of every entry goes out serially once per frame.
// RULE16 - Control bits lead their channel by one slot, stream 0 first.
// RULE17 - Frame pulse low resets the bit and channel counter at next clock fall.
// RULE18 - Memory address takes upper bits from control register, lower from lines.
// RULE19 - Each received serial byte is stored at its stream and channel.
// RULE20 - Acknowledge is pulled low when the access is complete.
// RULE21 - Outside split mode reads return the selected memory and stream contents.
`timescale 1ns/1ns
`include "tsw_defs.svh"
module tsw_switch
   import tsw_pkg::*;
#(
   parameter int FIFO_DEPTH = `TSW_FIFO_DEPTH
) (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_srst,
   // Processor bus
   input wire logic i_cs_n,
   input wire logic i_data_strobe_in,
   input wire logic i_read_write,
   input wire logic i_page_select_line,
   input wire logic [4:0] i_channel_addr_lines,
   input wire logic [7:0] i_data,
   output logic [7:0] o_data,
   output logic o_data_oe,
   input wire logic i_access_ack_n,
   output logic o_access_ack_n,
   output logic o_access_ack_n_oe,
   // Serial side
   input wire logic i_bit_clock_4m,
   input wire logic i_frame_pulse_in_n,
   input wire logic i_output_drive_enable,
   input wire logic [7:0] i_serial_input_streams,
   output logic [7:0] o_serial_output_streams,
   output logic [7:0] o_serial_output_streams_oe,
   output logic o_control_bit_serial_out
);

   localparam int NS = `TSW_STREAMS;
   localparam int NW = `TSW_MEM_WORDS;
   localparam int RXW = $bits(tsw_rx_s);

   // Memories: data, low connection and high connection, indexed {stream, channel}.
   logic [7:0] dmem_q [NW];
   logic [7:0] cml_q [NW];
   logic [7:0] cmh_q [NW];

   // ---------------------------------------------------------------
   // Processor access
   // ---------------------------------------------------------------
   tsw_bus_e bus_q, bus_d;
   logic [7:0] ctrl_q, ctrl_d;
   logic [7:0] rdata_q, rdata_d;
   logic is_read_q, is_read_d;
   logic [7:0] mem_idx;
   logic [1:0] msel;
   logic split, gmsg;
   logic start;
   logic wr_cml, wr_cmh;
   logic rd_dmem;

   assign msel = ctrl_q[`TSW_CTRL_MSEL_MSB:`TSW_CTRL_MSEL_LSB]; // see RULE3
   assign split = ctrl_q[`TSW_CTRL_SPLIT_BIT];
   assign gmsg = ctrl_q[`TSW_CTRL_GMSG_BIT];
   // Upper address bits come from the stream field, lower from the bus lines.
   assign mem_idx = {ctrl_q[`TSW_CTRL_STRM_MSB:`TSW_CTRL_STRM_LSB],
                     i_channel_addr_lines}; // see RULE18 see RULE4 see RULE2
   assign start = (bus_q == TSW_BUS_IDLE) & ~i_cs_n & i_data_strobe_in;
   // Split mode sends writes to the low connection memory whatever the select says.
   assign wr_cml = start & ~i_read_write & i_page_select_line
                   & (split | (msel == `TSW_MSEL_CML)); // see RULE6
   assign wr_cmh = start & ~i_read_write & i_page_select_line & ~split
                   & (msel == `TSW_MSEL_CMH);
   assign rd_dmem = start & i_read_write & i_page_select_line
                    & (split | (msel == `TSW_MSEL_DATA));

   always_comb begin
      bus_d = bus_q;
      ctrl_d = ctrl_q;
      rdata_d = rdata_q;
      is_read_d = is_read_q;
      case (bus_q)
         TSW_BUS_IDLE: begin
            if (start) begin
               bus_d = TSW_BUS_ACK;
               is_read_d = i_read_write;
               if (!i_page_select_line) begin
                  // Channel lines play no part in a control register access.
                  if (i_read_write) begin
                     rdata_d = ctrl_q; // see RULE1
                  end else begin
                     ctrl_d = i_data; // see RULE1 see RULE5
                  end
               end else if (split) begin
                  rdata_d = dmem_q[mem_idx]; // see RULE6
               end else begin
                  // Select pattern 00 is test-reserved and reads back zero.
                  case (msel)
                     `TSW_MSEL_DATA: rdata_d = dmem_q[mem_idx]; // see RULE21
                     `TSW_MSEL_CML: rdata_d = cml_q[mem_idx]; // see RULE21
                     `TSW_MSEL_CMH: rdata_d = cmh_q[mem_idx]; // see RULE21
                     default: rdata_d = 8'h00;
                  endcase
               end
            end
         end
         TSW_BUS_ACK: begin
            // Hold the acknowledge until the processor withdraws the strobe or the chip select.
            if (i_cs_n | ~i_data_strobe_in) begin
               bus_d = TSW_BUS_IDLE;
            end
         end
         default: bus_d = TSW_BUS_IDLE;
      endcase
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         bus_q <= TSW_BUS_IDLE;
         ctrl_q <= `TSW_CTRL_RST;
         rdata_q <= 8'h00;
         is_read_q <= 1'b0;
      end else begin
         bus_q <= bus_d;
         ctrl_q <= ctrl_d;
         rdata_q <= rdata_d;
         is_read_q <= is_read_d;
      end
   end

   assign o_data = rdata_q;
   assign o_data_oe = (bus_q == TSW_BUS_ACK) & is_read_q;
   assign o_access_ack_n = 1'b0;
   assign o_access_ack_n_oe = (bus_q == TSW_BUS_ACK); // see RULE20

   // ---------------------------------------------------------------
   // Frame timing: 512 bit-clock falls per frame, two per bit cell
   // ---------------------------------------------------------------
   logic bclk_q;
   logic fall;
   logic [9:0] cnt_q, cnt_d;
   logic [4:0] nxt_chan;
   logic [2:0] nxt_bit;

   assign fall = bclk_q & ~i_bit_clock_4m;

   always_comb begin
      cnt_d = cnt_q;
      if (fall) begin
         cnt_d = i_frame_pulse_in_n ? cnt_q + 10'h001 : 10'h000; // see RULE17
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         bclk_q <= 1'b0;
         cnt_q <= 10'h000;
      end else begin
         bclk_q <= i_bit_clock_4m;
         cnt_q <= cnt_d;
      end
   end

   assign nxt_chan = cnt_d[8:4];
   assign nxt_bit = cnt_d[3:1];

   // ---------------------------------------------------------------
   // Receive path: shift in at mid-cell, queue completed bytes
   // ---------------------------------------------------------------
   logic [7:0] rx_sh_q [NS];
   logic [7:0] rx_sh_d [NS];
   logic [7:0] rx_hold_q [NS];
   logic [7:0] rx_hold_d [NS];
   logic [7:0] pend_q, pend_d;
   logic [4:0] rx_chan_q, rx_chan_d;
   logic [2:0] pick;
   tsw_rx_s push_word, pop_word;

   tsw_fifo_if #(.W(RXW)) rx_wr ();
   tsw_fifo_if #(.W(RXW)) rx_rd ();

   // Lowest pending stream goes first so the queue fills in stream order.
   always_comb begin
      pick = 3'h0;
      for (int s = NS - 1; s >= 0; s--) begin
         if (pend_q[s]) begin
            pick = 3'(s);
         end
      end
   end

   assign push_word = '{stream: pick, chan: rx_chan_q, data: rx_hold_q[pick]};
   assign rx_wr.valid = (pend_q != 8'h00);
   assign rx_wr.data = push_word;

   always_comb begin
      pend_d = pend_q;
      rx_chan_d = rx_chan_q;
      for (int s = 0; s < NS; s++) begin
         rx_sh_d[s] = rx_sh_q[s];
         rx_hold_d[s] = rx_hold_q[s];
      end
      // A full queue stalls the pusher; the word stays pending until room appears.
      if (rx_wr.valid & rx_wr.ready) begin
         pend_d[pick] = 1'b0;
      end
      if (fall & cnt_d[0]) begin
         for (int s = 0; s < NS; s++) begin
            rx_sh_d[s] = {rx_sh_q[s][6:0], i_serial_input_streams[s]}; // see RULE19
         end
         if (cnt_d[3:0] == 4'hF) begin
            // A new byte overtakes any word of the last channel still pending.
            for (int s = 0; s < NS; s++) begin
               rx_hold_d[s] = {rx_sh_q[s][6:0], i_serial_input_streams[s]};
            end
            rx_chan_d = nxt_chan;
            pend_d = 8'hFF; // see RULE19
         end
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         pend_q <= 8'h00;
         rx_chan_q <= 5'h00;
         for (int s = 0; s < NS; s++) begin
            rx_sh_q[s] <= 8'h00;
            rx_hold_q[s] <= 8'h00;
         end
      end else begin
         pend_q <= pend_d;
         rx_chan_q <= rx_chan_d;
         for (int s = 0; s < NS; s++) begin
            rx_sh_q[s] <= rx_sh_d[s];
            rx_hold_q[s] <= rx_hold_d[s];
         end
      end
   end

   tsw_fifo #(
      .W(RXW),
      .DEPTH(FIFO_DEPTH)
   ) u_rx_fifo (
      .i_sys_clk(i_sys_clk),
      .i_srst(i_srst),
      .wr(rx_wr),
      .rd(rx_rd)
   );

   // Draining pauses while the processor reads data memory, so the read sees a stable word.
   assign pop_word = rx_rd.data;
   assign rx_rd.ready = ~rd_dmem;

   // ---------------------------------------------------------------
   // Memory writes (cleared by reset so outputs never carry unknowns)
   // ---------------------------------------------------------------
   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         for (int i = 0; i < NW; i++) begin
            dmem_q[i] <= 8'h00;
            cml_q[i] <= 8'h00;
            cmh_q[i] <= 8'h00;
         end
      end else begin
         if (rx_rd.valid & rx_rd.ready) begin
            dmem_q[{pop_word.stream, pop_word.chan}] <= pop_word.data; // see RULE19
         end
         if (wr_cml) begin
            cml_q[mem_idx] <= i_data; // see RULE6 see RULE18
         end
         if (wr_cmh) begin
            cmh_q[mem_idx] <= i_data;
         end
      end
   end

   // ---------------------------------------------------------------
   // Transmit path and control-bit stream
   // ---------------------------------------------------------------
   logic [7:0] tx_sh_q [NS];
   logic [7:0] tx_sh_d [NS];
   logic [7:0] tx_en_q, tx_en_d;
   logic ctl_q, ctl_d;
   logic [7:0] hi_ent, lo_ent;
   logic [7:0] ctl_ent;
   logic [4:0] ahead_chan;

   assign ahead_chan = nxt_chan + 5'h01;
   assign ctl_ent = cmh_q[{nxt_bit, ahead_chan}];

   always_comb begin
      hi_ent = 8'h00;
      lo_ent = 8'h00;
      tx_en_d = tx_en_q;
      ctl_d = ctl_q;
      for (int s = 0; s < NS; s++) begin
         tx_sh_d[s] = tx_sh_q[s];
      end
      if (fall & ~cnt_d[0]) begin
         // Bit for stream n of the next channel goes out in bit cell n.
         ctl_d = ctl_ent[`TSW_CMH_CTL_BIT]; // see RULE15 see RULE16
         if (cnt_d[3:0] == 4'h0) begin
            for (int s = 0; s < NS; s++) begin
               hi_ent = cmh_q[{3'(s), nxt_chan}];
               lo_ent = cml_q[{3'(s), nxt_chan}];
               if (gmsg) begin
                  hi_ent[`TSW_CMH_MSG_BIT] = 1'b1; // see RULE8 see RULE7
                  hi_ent[`TSW_CMH_OE_BIT] = 1'b1; // see RULE8 see RULE13
               end
               if (hi_ent[`TSW_CMH_MSG_BIT]) begin
                  tx_sh_d[s] = lo_ent; // see RULE9 see RULE7
               end else begin
                  tx_sh_d[s] = dmem_q[{lo_ent[`TSW_CML_STRM_MSB:`TSW_CML_STRM_LSB],
                                       lo_ent[`TSW_CML_CHAN_MSB:`TSW_CML_CHAN_LSB]}];
                  // see RULE10 see RULE11
               end
               tx_en_d[s] = hi_ent[`TSW_CMH_OE_BIT]; // see RULE14
            end
         end else begin
            for (int s = 0; s < NS; s++) begin
               tx_sh_d[s] = {tx_sh_q[s][6:0], 1'b0};
            end
         end
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         tx_en_q <= 8'h00;
         ctl_q <= 1'b0;
         for (int s = 0; s < NS; s++) begin
            tx_sh_q[s] <= 8'h00;
         end
      end else begin
         tx_en_q <= tx_en_d;
         ctl_q <= ctl_d;
         for (int s = 0; s < NS; s++) begin
            tx_sh_q[s] <= tx_sh_d[s];
         end
      end
   end

   always_comb begin
      for (int s = 0; s < NS; s++) begin
         o_serial_output_streams[s] = tx_sh_q[s][7];
      end
   end

   // The pin overrides the stream enables held in registers and memory; the control-bit output is not gated.
   assign o_serial_output_streams_oe = tx_en_q & {NS{i_output_drive_enable}};
   // see RULE12 see RULE13 see RULE14
   assign o_control_bit_serial_out = ctl_q;

endmodule

// [verilog/tsw_defs.svh]
// Register fields, memory entry fields, reset values and sizes of the switch control block.
`ifndef TSW_DEFS_SVH
`define TSW_DEFS_SVH

`define TSW_CTRL_RST 8'h00
`define TSW_CTRL_SPLIT_BIT 7
`define TSW_CTRL_GMSG_BIT 6
`define TSW_CTRL_MSEL_MSB 4
`define TSW_CTRL_MSEL_LSB 3
`define TSW_CTRL_STRM_MSB 2
`define TSW_CTRL_STRM_LSB 0

`define TSW_MSEL_DATA 2'h1
`define TSW_MSEL_CML 2'h2
`define TSW_MSEL_CMH 2'h3

`define TSW_CMH_MSG_BIT 2
`define TSW_CMH_CTL_BIT 1
`define TSW_CMH_OE_BIT 0
`define TSW_CML_STRM_MSB 7
`define TSW_CML_STRM_LSB 5
`define TSW_CML_CHAN_MSB 4
`define TSW_CML_CHAN_LSB 0

`define TSW_STREAMS 8
`define TSW_CHANNELS 32
`define TSW_MEM_WORDS 256
`define TSW_FIFO_DEPTH 16

`endif

// [verilog/tsw_pkg.sv]
// Types shared by the switch control block and its receive FIFO.
package tsw_pkg;

   typedef enum logic [1:0] {
      TSW_BUS_IDLE = 2'b00,
      TSW_BUS_ACK = 2'b01
   } tsw_bus_e;

   typedef struct packed {
      logic [2:0] stream;
      logic [4:0] chan;
      logic [7:0] data;
   } tsw_rx_s;

endpackage

// [verilog/tsw_fifo_if.sv]
// Valid/ready carrier between the receive path and its FIFO.
`timescale 1ns/1ns
interface tsw_fifo_if #(parameter int W = 16);
   logic valid;
   logic ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

// [verilog/tsw_fifo.sv]
// Synchronous FIFO with valid/ready on both sides.
`timescale 1ns/1ns
module tsw_fifo
   import tsw_pkg::*;
#(
   parameter int W = 16,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_srst,
   // Filling and draining sides
   tsw_fifo_if.snk wr,
   tsw_fifo_if.src rd
);

   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);

   logic [W-1:0] mem_q [DEPTH];
   logic [AW-1:0] wptr_q, wptr_d, rptr_q, rptr_d;
   logic [CW-1:0] cnt_q, cnt_d;
   logic push, pop;

   assign wr.ready = (cnt_q != CW'(DEPTH));
   assign rd.valid = (cnt_q != '0);
   assign rd.data = mem_q[rptr_q];
   assign push = wr.valid & wr.ready;
   assign pop = rd.valid & rd.ready;

   always_comb begin
      wptr_d = wptr_q;
      rptr_d = rptr_q;
      cnt_d = cnt_q;
      if (push) begin
         wptr_d = (wptr_q == AW'(DEPTH - 1)) ? '0 : wptr_q + 1'b1;
      end
      if (pop) begin
         rptr_d = (rptr_q == AW'(DEPTH - 1)) ? '0 : rptr_q + 1'b1;
      end
      if (push & ~pop) begin
         cnt_d = cnt_q + 1'b1;
      end else if (pop & ~push) begin
         cnt_d = cnt_q - 1'b1;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         wptr_q <= '0;
         rptr_q <= '0;
         cnt_q <= '0;
      end else begin
         wptr_q <= wptr_d;
         rptr_q <= rptr_d;
         cnt_q <= cnt_d;
      end
   end

   // Storage needs no reset; only words below the count are ever read.
   always_ff @(posedge i_sys_clk) begin
      if (push) begin
         mem_q[wptr_q] <= wr.data;
      end
   end

endmodule

// [sim/tsw_switch_asserts.sv]
// Concurrent checks of the processor handshake and serial output enables.
`timescale 1ns/1ns
module tsw_switch_asserts #(
   parameter int FIFO_DEPTH = 16
) (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_srst,
   // Watched bus and serial signals
   input wire logic i_cs_n,
   input wire logic i_data_strobe_in,
   input wire logic i_read_write,
   input wire logic i_output_drive_enable,
   input wire logic o_data_oe,
   input wire logic o_access_ack_n,
   input wire logic o_access_ack_n_oe,
   input wire logic [7:0] o_serial_output_streams_oe
);
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_srst);

   // A request counts as new only after a released strobe and an idle answer.
   sequence s_req;
      !i_cs_n && i_data_strobe_in && !o_access_ack_n_oe && !$past(o_access_ack_n_oe)
         && !$past(i_data_strobe_in);
   endsequence
   sequence s_drop;
      o_access_ack_n_oe && (i_cs_n || !i_data_strobe_in);
   endsequence

   chk_ack_after_req: assert property (s_req |=> o_access_ack_n_oe)
      else $error("acknowledge missing one cycle after request");
   chk_rd_answer: assert property (s_req ##0 i_read_write |=> o_data_oe)
      else $error("read data not driven with acknowledge");
   chk_ack_stands: assert property (o_access_ack_n_oe && !i_cs_n && i_data_strobe_in
      |=> o_access_ack_n_oe)
      else $error("acknowledge withdrawn while strobe held");
   chk_ack_drops: assert property (s_drop |=> !o_access_ack_n_oe [*2])
      else $error("acknowledge kept after strobe release");
   chk_no_idle_ack: assert property (!o_access_ack_n_oe && (i_cs_n || !i_data_strobe_in)
      |=> !o_access_ack_n_oe)
      else $error("acknowledge without request");
   chk_ack_pulls_low: assert property (o_access_ack_n_oe |-> !o_access_ack_n)
      else $error("acknowledge not pulled low");
   chk_rd_drive: assert property (o_data_oe |-> o_access_ack_n_oe && i_read_write)
      else $error("data pins driven outside a read answer");
   chk_wr_quiet: assert property (o_access_ack_n_oe && !i_read_write |-> !o_data_oe)
      else $error("data pins driven during a write");
   chk_ode_float: assert property (!i_output_drive_enable
      |-> o_serial_output_streams_oe == 8'h00)
      else $error("serial driver enabled with drive enable low");
endmodule

bind tsw_switch tsw_switch_asserts #(.FIFO_DEPTH(FIFO_DEPTH)) u_chk (.i_sys_clk, .i_srst,
   .i_cs_n, .i_data_strobe_in, .i_read_write, .i_output_drive_enable, .o_data_oe,
   .o_access_ack_n, .o_access_ack_n_oe, .o_serial_output_streams_oe);

// [sim/tsw_cpu_model.sv]
// Processor bus master and serial stream source facing the switch control block.
`timescale 1ns/1ns
module tsw_cpu_model (
   // Clock
   input wire logic i_sys_clk,
   // Processor bus
   output logic o_cs_n,
   output logic o_strobe,
   output logic o_rw,
   output logic o_page,
   output logic [4:0] o_addr,
   output logic [7:0] o_wdata,
   input wire logic [7:0] i_rdata,
   input wire logic i_ack_oe,
   // Serial side
   output logic o_bclk,
   output logic o_frame_n,
   output logic [7:0] o_sin,
   output logic [8:0] o_fall_k
);
   logic [2:0] ph = 3'h0;
   logic [8:0] nk;
   logic [7:0] src;

   initial begin
      o_cs_n = 1'b1;
      o_strobe = 1'b0;
      o_rw = 1'b1;
      o_page = 1'b0;
      o_addr = 5'h00;
      o_wdata = 8'h00;
      o_bclk = 1'b1;
      o_frame_n = 1'b0;
      o_sin = 8'h00;
      o_fall_k = 9'h1FF;
   end

   // Bit clock of five system cycles; each input byte is {stream, channel}.
   always @(negedge i_sys_clk) begin
      nk = o_fall_k + 9'h001;
      ph <= (ph == 3'h4) ? 3'h0 : ph + 3'h1;
      if (ph == 3'h4) begin
         o_bclk <= 1'b1;
         o_frame_n <= (o_fall_k != 9'h1FF);
      end
      if (ph == 3'h2) begin
         o_bclk <= 1'b0;
         o_fall_k <= nk;
         for (int s = 0; s < 8; s++) begin
            src = {3'(s), nk[8:4]};
            if (!nk[0]) o_sin[s] <= src[3'h7 - nk[3:1]];
         end
      end
   end

   // Released lines show inverted values so a stale sample cannot pass.
   task automatic access(input logic wr, input logic page, input logic [4:0] ch,
      input logic [7:0] d, output logic [7:0] q, output logic ok);
      int n;
      @(negedge i_sys_clk);
      o_cs_n <= 1'b0;
      o_strobe <= 1'b1;
      o_rw <= !wr;
      o_page <= page;
      o_addr <= ch;
      o_wdata <= wr ? d : ~d;
      n = 0;
      do begin
         @(posedge i_sys_clk);
         n++;
      end while (i_ack_oe !== 1'b1 && n < 20);
      q = i_rdata;
      ok = (i_ack_oe === 1'b1);
      @(negedge i_sys_clk);
      o_cs_n <= 1'b1;
      o_strobe <= 1'b0;
      o_page <= !page;
      o_addr <= ~ch;
      o_wdata <= ~o_wdata;
      n = 0;
      do begin
         @(posedge i_sys_clk);
         n++;
      end while (i_ack_oe !== 1'b0 && n < 20);
      ok = ok && (i_ack_oe === 1'b0);
      @(posedge i_sys_clk);
   endtask
endmodule

// [sim/tb.sv]
// Self-checking bench of the switch control block.
`timescale 1ns/1ns
module tb;
   logic sys_clk = 1'b0;
   logic srst = 1'b1;
   logic drive_en = 1'b1;
   wire cs_n, strobe, rw, page, bclk, frame_n, data_oe, ack_n, ack_oe, ack_wire, cso;
   wire [4:0] addr;
   wire [7:0] wdata, rdata, sin, sout, soe;
   wire [8:0] fall_k;
   int err_count = 0;
   int samples_checked = 0;
   logic [7:0] q, en, ctl;
   // Rows are {write, page, channel, data or expected read}.
   // Control writes use listed values only; the rest are kept for factory test.
   localparam logic [14:0] ROWS [15] = '{15'h4A13, 15'h65A5, 15'h4012, 15'h653C,
      15'h4013, 15'h25A5, 15'h1F13, 15'h401B, 15'h6507, 15'h2507,
      15'h4013, 15'h65FF, 15'h25FF, 15'h4012, 15'h253C};

   always #25 sys_clk = ~sys_clk;
   assign ack_wire = ack_oe ? ack_n : 1'b1;

   tsw_switch #(.FIFO_DEPTH(16)) dut (.i_sys_clk(sys_clk), .i_srst(srst), .i_cs_n(cs_n),
      .i_data_strobe_in(strobe), .i_read_write(rw), .i_page_select_line(page),
      .i_channel_addr_lines(addr), .i_data(wdata), .o_data(rdata), .o_data_oe(data_oe),
      .i_access_ack_n(ack_wire), .o_access_ack_n(ack_n), .o_access_ack_n_oe(ack_oe),
      .i_bit_clock_4m(bclk), .i_frame_pulse_in_n(frame_n),
      .i_output_drive_enable(drive_en), .i_serial_input_streams(sin),
      .o_serial_output_streams(sout), .o_serial_output_streams_oe(soe),
      .o_control_bit_serial_out(cso));
   tsw_cpu_model cpu (.i_sys_clk(sys_clk), .o_cs_n(cs_n), .o_strobe(strobe), .o_rw(rw),
      .o_page(page), .o_addr(addr), .o_wdata(wdata), .i_rdata(rdata), .i_ack_oe(ack_oe),
      .o_bclk(bclk), .o_frame_n(frame_n), .o_sin(sin), .o_fall_k(fall_k));

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic complete_run();
      $display("Checks %0d, mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic bus(input logic wr, input logic pg, input logic [4:0] ch,
      input logic [7:0] d, output logic [7:0] rq);
      logic ok;
      cpu.access(wr, pg, ch, d, rq, ok);
      check({7'h00, ok}, 8'h01);
   endtask

   task automatic wait_k(input logic [8:0] t);
      int n;
      n = 0;
      while (fall_k !== t && n < 3000) begin
         @(negedge sys_clk);
         n++;
      end
      if (n >= 3000) begin
         err_count++;
         $display("Error at %0t: slot %h expected %h", $time, fall_k, t);
      end
   endtask

   // Waits for a fresh frame so settings written earlier are in force.
   task automatic slot(input logic [4:0] ch, input int s);
      wait_k(9'h1FF);
      for (int n = 0; n < 8; n++) begin
         wait_k({ch, 3'(n), 1'b1});
         q = {q[6:0], sout[s]};
         en = {en[6:0], soe[s]};
         ctl = {ctl[6:0], cso};
      end
   endtask

   initial begin
      repeat (2) @(negedge sys_clk);
      srst = 1'b0;
      check(soe, 8'h00);
      for (int i = 0; i < 15; i++) begin
         bus(ROWS[i][14], ROWS[i][13], ROWS[i][12:8], ROWS[i][7:0], q);
         if (!ROWS[i][14]) check(q, ROWS[i][7:0]);
      end
      bus(1'b1, 1'b0, 5'h00, 8'h10, q);
      bus(1'b1, 1'b1, 5'h02, 8'h24, q);
      bus(1'b1, 1'b1, 5'h03, 8'hC3, q);
      bus(1'b1, 1'b0, 5'h00, 8'h18, q);
      bus(1'b1, 1'b1, 5'h02, 8'h01, q);
      bus(1'b1, 1'b1, 5'h03, 8'h07, q);
      bus(1'b1, 1'b0, 5'h00, 8'h19, q);
      bus(1'b1, 1'b1, 5'h03, 8'h02, q);
      slot(5'h02, 0);
      check(q, 8'h24);
      check(en, 8'hFF);
      check(ctl, 8'hC0);
      slot(5'h03, 0);
      check(q, 8'hC3);
      slot(5'h04, 0);
      check(en, 8'h00);
      bus(1'b1, 1'b0, 5'h00, 8'h0C, q);
      bus(1'b0, 1'b1, 5'h09, 8'h00, q);
      check(q, 8'h89);
      bus(1'b1, 1'b0, 5'h00, 8'h89, q);
      bus(1'b0, 1'b1, 5'h04, 8'h00, q);
      check(q, 8'h24);
      bus(1'b1, 1'b1, 5'h06, 8'h77, q);
      bus(1'b1, 1'b0, 5'h00, 8'h11, q);
      bus(1'b0, 1'b1, 5'h06, 8'h00, q);
      check(q, 8'h77);
      bus(1'b1, 1'b0, 5'h00, 8'h50, q);
      bus(1'b1, 1'b1, 5'h04, 8'h99, q);
      slot(5'h04, 0);
      check(q, 8'h99);
      check(en, 8'hFF);
      @(negedge sys_clk);
      drive_en = 1'b0;
      slot(5'h04, 0);
      check(en, 8'h00);
      drive_en = 1'b1;
      srst = 1'b1;
      repeat (2) @(negedge sys_clk);
      srst = 1'b0;
      bus(1'b0, 1'b0, 5'h00, 8'h00, q);
      check(q, 8'h00);
      bus(1'b1, 1'b0, 5'h00, 8'h10, q);
      bus(1'b0, 1'b1, 5'h02, 8'h00, q);
      check(q, 8'h00);
      complete_run();
   end

   // Five slot captures take at most ten frames; the limit leaves ample margin.
   initial begin
      repeat (90000) @(posedge sys_clk);
      err_count++;
      $display("Error at %0t: watchdog %h expected %h", $time, 1'b1, 1'b0);
      complete_run();
   end
endmodule
